/* File: pkg/ess_pkg.sv */
// constants and types for the engine start/stop supervisor
package ess_pkg;
    localparam int ESS_CLK_HZ = 125000000;
    localparam int ESS_TICK_S = 1;
    localparam int ESS_TICK_CYCLES = ESS_CLK_HZ * ESS_TICK_S;
    localparam logic [15:0] ESS_NOM_RPM1_RST = 16'h05DC;
    localparam logic [15:0] ESS_NOM_RPM2_RST = 16'h0708;
    localparam logic [15:0] ESS_NOM_RPM3_RST = 16'h0708;
    localparam logic [6:0] ESS_LOW_WARN_PCT_RST = 7'h0A;
    localparam logic [6:0] ESS_LOW_SD_PCT_RST = 7'h0F;
    localparam logic [6:0] ESS_HIGH_WARN_PCT_RST = 7'h0A;
    localparam logic [6:0] ESS_HIGH_SD_PCT_RST = 7'h0F;
    localparam logic [6:0] ESS_OVERSHOOT_PCT_RST = 7'h0A;
    localparam logic [3:0] ESS_SPEED_FAIL_S_RST = 4'h3;
    localparam logic [7:0] ESS_LOSS_S_RST = 8'h00;
    localparam logic [1:0] ESS_LOSS_ACT_RST = 2'h0;
    localparam logic [1:0] ESS_LOSS_ACT_SHUTDOWN = 2'h0;
    localparam logic [1:0] ESS_LOSS_ACT_DUMP = 2'h1;
    localparam logic [1:0] ESS_LOSS_ACT_WARN = 2'h2;
    localparam logic [9:0] ESS_CHG_WARN_DV_RST = 10'h03C;
    localparam logic [9:0] ESS_CHG_SD_DV_RST = 10'h028;
    localparam logic [6:0] ESS_CHG_FAIL_S_RST = 7'h01;
    localparam logic [9:0] ESS_START_DLY_MIN_RST = 10'h001;
    localparam logic [5:0] ESS_SEC_PER_MIN = 6'h3C;
    localparam logic [4:0] ESS_PREHEAT_S_RST = 5'h00;
    localparam logic [3:0] ESS_CRANK_S_RST = 4'h6;
    localparam logic [7:0] ESS_WAIT_S_RST = 8'h0A;
    localparam logic [2:0] ESS_STARTS_RST = 3'h3;
    localparam logic [7:0] ESS_HEAT_S_RST = 8'h04;
    localparam logic [9:0] ESS_COOL_S_RST = 10'h078;
    localparam logic [6:0] ESS_STOP_S_RST = 7'h0A;
    localparam logic [7:0] ESS_CHOKE_S_RST = 8'h05;
    localparam logic [15:0] ESS_CRANK_CUT_RPM_RST = 16'h01F4;
    localparam logic [6:0] ESS_PCT_FULL = 7'h64;
    typedef enum logic [3:0] {
        ESS_ST_STOPPED, ESS_ST_START_DELAY, ESS_ST_PREHEAT, ESS_ST_CRANK,
        ESS_ST_WAIT, ESS_ST_HEATING, ESS_ST_LOADED, ESS_ST_COOLDOWN,
        ESS_ST_STOPPING, ESS_ST_FAILED
    } ess_state_e;
endpackage

/* File: src/ess_sec_timer.sv */
// seconds counter advanced by a shared tick
`timescale 1ns/100ps
`default_nettype none
module ess_sec_timer
    import ess_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic clear,
    input wire logic tick,
    output logic [15:0] count
);
    // counts up on tick, saturates, clear wins
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= 16'h0000;
        end else if (ce) begin
            if (clear) begin
                count <= 16'h0000;
            end else if (tick && count != 16'hFFFF) begin
                count <= count + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

/* File: src/ess_supervisor.sv */
// engine start/stop sequencer with speed and charge supervision
`timescale 1ns/100ps
`default_nettype none
// How it works
// RQ1: nominal speed chosen from three values; all speed limits scale from it.
// RQ2: while loaded, low speed warns below -10 percent, stops below -15 percent.
// RQ3: while loaded, high speed warns above +10 percent, stops above +15 percent.
// RQ4: speed fault only after out of limits for the fail time.
// RQ5: speed beyond trip level plus overshoot stops the engine at once.
// RQ6: signal-loss check enable; when off, loss is ignored.
// RQ7: loss action code: 0 shutdown, 1 load dump, 2 warning.
// RQ8: signal loss declared only after loss timer, 0 to 240 s.
// RQ9: charge voltage warns below 6.0 V, shuts down below 4.0 V.
// RQ10: charge fault only after voltage low for its fail time.
// RQ11: after mains failure wait start delay minutes before fuel on.
// RQ12: glow output held during preheat time before cranking.
// RQ13: each crank limited to crank time; ends early when fired.
// RQ14: pause between cranks; no more attempts than programmed count.
// RQ15: load withheld until heating done, by timer or temperature plus timer.
// RQ16: after load returns to mains run unloaded for cooldown time.
// RQ17: stop output held for stop time, then stop-failure warning.
// RQ18: choke on with crank, released after choke delay or engine running.
// RQ19: engine fired when speed reaches crank-cut speed.
// RQ20: all timers from one-second tick; reset clears timers, stops engine.
module ess_supervisor
    import ess_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic sync_rst,
    input wire logic mains_fail,
    input wire logic [15:0] engine_rpm,
    input wire logic speed_signal_present,
    input wire logic [9:0] charge_dv,
    input wire logic [7:0] coolant_temp,
    input wire logic [1:0] freq_select,
    input wire logic [15:0] nominal_rpm1,
    input wire logic [15:0] nominal_rpm2,
    input wire logic [15:0] nominal_rpm3,
    input wire logic [6:0] low_warn_pct,
    input wire logic [6:0] low_sd_pct,
    input wire logic [6:0] high_warn_pct,
    input wire logic [6:0] high_sd_pct,
    input wire logic [6:0] overshoot_pct,
    input wire logic [3:0] speed_fail_s,
    input wire logic loss_check_en,
    input wire logic [1:0] loss_action,
    input wire logic [7:0] loss_s,
    input wire logic [9:0] chg_warn_dv,
    input wire logic [9:0] chg_sd_dv,
    input wire logic [6:0] chg_fail_s,
    input wire logic [9:0] start_delay_min,
    input wire logic [4:0] preheat_s,
    input wire logic [3:0] crank_s,
    input wire logic [7:0] wait_s,
    input wire logic [2:0] num_starts,
    input wire logic [7:0] heat_s,
    input wire logic heat_method,
    input wire logic [7:0] heat_temp,
    input wire logic [9:0] cool_s,
    input wire logic [6:0] stop_s,
    input wire logic [7:0] choke_s,
    input wire logic [15:0] crank_cut_rpm,
    output logic fuel_out,
    output logic glow_out,
    output logic crank_out,
    output logic choke_out,
    output logic stop_out,
    output logic load_enable,
    output logic low_speed_warning,
    output logic high_speed_warning,
    output logic speed_shutdown,
    output logic signal_lost_shutdown,
    output logic signal_lost_dump,
    output logic signal_lost_warning,
    output logic charge_warning,
    output logic charge_shutdown,
    output logic stop_failure_warning,
    output logic start_failure,
    output logic [3:0] state_code
);
    ////////////////////////////////////////////////////////////////////////////
    // pin synchroniser for mains_fail and speed presence
    logic [2:0] mf_sync;
    logic [2:0] sp_sync;
    logic mains_fail_q;
    logic speed_present_q;

    // three stages; change taken when stages two and three agree
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mf_sync <= 3'h0;
            sp_sync <= 3'h0;
            mains_fail_q <= 1'b0;
            speed_present_q <= 1'b0;
        end else if (ce) begin
            mf_sync <= {mf_sync[1:0], mains_fail};
            sp_sync <= {sp_sync[1:0], speed_signal_present};
            if (mf_sync[1] == mf_sync[2]) begin
                mains_fail_q <= mf_sync[2];
            end
            if (sp_sync[1] == sp_sync[2]) begin
                speed_present_q <= sp_sync[2];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // one-second tick
    logic [26:0] tick_cnt;
    logic tick;

    // divides the system clock down to one pulse per second
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            tick_cnt <= 27'h0000000;
            tick <= 1'b0;
        end else if (ce) begin
            if (sync_rst || tick_cnt == 27'(ESS_TICK_CYCLES - 1)) begin
                tick_cnt <= 27'h0000000;
                tick <= !sync_rst; // RQ20
            end else begin
                tick_cnt <= tick_cnt + 27'h0000001;
                tick <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // speed limits
    logic [15:0] nominal;
    logic [15:0] upper_speed_trip_level;

    // base times (100 +/- pct) / 100, saturated to 16 bits
    function automatic logic [15:0] scale_pct(input logic [15:0] base,
                                              input logic [6:0] pct, input logic up);
        logic [23:0] prod;
        logic [7:0] factor;
        factor = up ? 8'(ESS_PCT_FULL) + 8'(pct) : 8'(ESS_PCT_FULL) - 8'(pct);
        prod = 24'(base) * 24'(factor) / 24'(ESS_PCT_FULL);
        scale_pct = (prod > 24'h00FFFF) ? 16'hFFFF : prod[15:0];
    endfunction

    always_comb begin
        unique case (freq_select) // RQ1
            2'h1: nominal = nominal_rpm2;
            2'h2: nominal = nominal_rpm3;
            default: nominal = nominal_rpm1;
        endcase
    end
    assign upper_speed_trip_level = scale_pct(nominal, high_sd_pct, 1'b1); // RQ1

    logic low_warn_now;
    logic low_sd_now;
    logic high_warn_now;
    logic high_sd_now;
    logic overshoot_now;
    assign low_warn_now = engine_rpm < scale_pct(nominal, low_warn_pct, 1'b0); // RQ2
    assign low_sd_now = engine_rpm < scale_pct(nominal, low_sd_pct, 1'b0); // RQ2
    assign high_warn_now = engine_rpm > scale_pct(nominal, high_warn_pct, 1'b1); // RQ3
    assign high_sd_now = engine_rpm > upper_speed_trip_level; // RQ3
    assign overshoot_now = engine_rpm > scale_pct(upper_speed_trip_level, overshoot_pct, 1'b1); // RQ5

    ////////////////////////////////////////////////////////////////////////////
    // timers
    ess_state_e state;
    logic seq_clr;
    logic [15:0] seq_cnt;
    logic spd_clr;
    logic [15:0] spd_cnt;
    logic loss_clr;
    logic [15:0] loss_cnt;
    logic chg_clr;
    logic [15:0] chg_cnt;
    logic stp_clr;
    logic [15:0] stp_cnt;
    logic [15:0] start_delay_s;
    logic state_change;
    logic loaded;
    logic fired;
    logic shutdown_req;

    assign start_delay_s = 16'(start_delay_min) * 16'(ESS_SEC_PER_MIN); // RQ11
    assign loaded = (state == ESS_ST_LOADED);
    assign fired = engine_rpm >= crank_cut_rpm; // RQ19

    ess_sec_timer u_seq (.clk(clk), .rst_n(rst_n), .ce(ce), .clear(seq_clr), .tick(tick),
        .count(seq_cnt));
    ess_sec_timer u_spd (.clk(clk), .rst_n(rst_n), .ce(ce), .clear(spd_clr), .tick(tick),
        .count(spd_cnt));
    ess_sec_timer u_loss (.clk(clk), .rst_n(rst_n), .ce(ce), .clear(loss_clr), .tick(tick),
        .count(loss_cnt));
    ess_sec_timer u_chg (.clk(clk), .rst_n(rst_n), .ce(ce), .clear(chg_clr), .tick(tick),
        .count(chg_cnt));
    ess_sec_timer u_stp (.clk(clk), .rst_n(rst_n), .ce(ce), .clear(stp_clr), .tick(tick),
        .count(stp_cnt));

    // supervision timers run only while their condition holds
    assign spd_clr = sync_rst || !loaded || !(low_warn_now || high_warn_now); // RQ4
    assign loss_clr = sync_rst || !loss_check_en || speed_present_q
                      || state < ESS_ST_HEATING || state > ESS_ST_COOLDOWN; // RQ6
    assign chg_clr = sync_rst || !(charge_dv < chg_warn_dv) || !loaded; // RQ10
    assign stp_clr = sync_rst || state != ESS_ST_STOPPING;
    assign seq_clr = sync_rst || state_change; // RQ20

    logic speed_expired;
    logic loss_expired;
    logic chg_expired;
    assign speed_expired = spd_cnt >= 16'(speed_fail_s); // RQ4
    assign loss_expired = loss_cnt >= 16'(loss_s); // RQ8
    assign chg_expired = chg_cnt >= 16'(chg_fail_s); // RQ10

    ////////////////////////////////////////////////////////////////////////////
    // alarms, sticky until reset
    // load-dump drops load and stops exactly like a shutdown, with cooldown skipped
    assign shutdown_req = speed_shutdown || charge_shutdown || signal_lost_shutdown
                          || signal_lost_dump;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            low_speed_warning <= 1'b0;
            high_speed_warning <= 1'b0;
            speed_shutdown <= 1'b0;
        end else if (ce) begin
            if (sync_rst) begin
                low_speed_warning <= 1'b0;
                high_speed_warning <= 1'b0;
                speed_shutdown <= 1'b0;
            end else begin
                if (loaded && low_warn_now && speed_expired) begin
                    low_speed_warning <= 1'b1; // RQ2
                end
                if (loaded && high_warn_now && speed_expired) begin
                    high_speed_warning <= 1'b1; // RQ3
                end
                if (loaded && (low_sd_now || high_sd_now) && speed_expired) begin
                    speed_shutdown <= 1'b1; // RQ2 RQ3
                end
                if (overshoot_now && state != ESS_ST_STOPPED) begin
                    speed_shutdown <= 1'b1; // RQ5
                end
            end
        end
    end

    // speed-signal loss, action chosen by code
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            signal_lost_shutdown <= 1'b0;
            signal_lost_dump <= 1'b0;
            signal_lost_warning <= 1'b0;
        end else if (ce) begin
            if (sync_rst) begin
                signal_lost_shutdown <= 1'b0;
                signal_lost_dump <= 1'b0;
                signal_lost_warning <= 1'b0;
            end else if (!loss_clr && loss_expired) begin
                unique case (loss_action) // RQ7
                    ESS_LOSS_ACT_SHUTDOWN: signal_lost_shutdown <= 1'b1;
                    ESS_LOSS_ACT_DUMP: signal_lost_dump <= 1'b1;
                    default: signal_lost_warning <= 1'b1;
                endcase
            end
        end
    end

    // charge alternator voltage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            charge_warning <= 1'b0;
            charge_shutdown <= 1'b0;
        end else if (ce) begin
            if (sync_rst) begin
                charge_warning <= 1'b0;
                charge_shutdown <= 1'b0;
            end else if (!chg_clr && chg_expired) begin
                charge_warning <= 1'b1; // RQ9
                if (charge_dv < chg_sd_dv) begin
                    charge_shutdown <= 1'b1; // RQ9
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // sequencer
    ess_state_e next_state;
    logic [2:0] attempts;

    always_comb begin
        next_state = state;
        unique case (state)
            ESS_ST_STOPPED: begin
                if (mains_fail_q && !shutdown_req) next_state = ESS_ST_START_DELAY;
            end
            ESS_ST_START_DELAY: begin
                if (!mains_fail_q) next_state = ESS_ST_STOPPED;
                else if (seq_cnt >= start_delay_s) next_state = ESS_ST_PREHEAT; // RQ11
            end
            ESS_ST_PREHEAT: begin
                if (seq_cnt >= 16'(preheat_s)) next_state = ESS_ST_CRANK; // RQ12
            end
            ESS_ST_CRANK: begin
                if (fired) next_state = ESS_ST_HEATING; // RQ13
                else if (seq_cnt >= 16'(crank_s)) begin
                    next_state = (attempts >= num_starts) ? ESS_ST_FAILED : ESS_ST_WAIT; // RQ14
                end
            end
            ESS_ST_WAIT: begin
                if (seq_cnt >= 16'(wait_s)) next_state = ESS_ST_CRANK; // RQ14
            end
            ESS_ST_HEATING: begin
                if (!mains_fail_q) next_state = ESS_ST_COOLDOWN;
                else if (seq_cnt >= 16'(heat_s)
                         && (!heat_method || coolant_temp >= heat_temp)) begin
                    next_state = ESS_ST_LOADED; // RQ15
                end
            end
            ESS_ST_LOADED: begin
                if (!mains_fail_q) next_state = ESS_ST_COOLDOWN;
            end
            ESS_ST_COOLDOWN: begin
                if (seq_cnt >= 16'(cool_s)) next_state = ESS_ST_STOPPING; // RQ16
                else if (mains_fail_q) next_state = ESS_ST_LOADED;
            end
            ESS_ST_STOPPING: begin
                if (seq_cnt >= 16'(stop_s) && engine_rpm == 16'h0000) begin
                    next_state = ESS_ST_STOPPED;
                end
            end
            ESS_ST_FAILED: begin
                next_state = ESS_ST_FAILED;
            end
            default: next_state = ESS_ST_STOPPED;
        endcase
        if (shutdown_req && state != ESS_ST_STOPPED && state != ESS_ST_STOPPING
            && state != ESS_ST_FAILED) begin
            next_state = ESS_ST_STOPPING; // RQ2 RQ9
        end
    end
    assign state_change = (next_state != state);

    // state register; synchronous reset returns to stopped
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ESS_ST_STOPPED;
        end else if (ce) begin
            state <= sync_rst ? ESS_ST_STOPPED : next_state; // RQ20
        end
    end

    // crank attempt counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            attempts <= 3'h0;
        end else if (ce) begin
            if (sync_rst || state == ESS_ST_STOPPED) begin
                attempts <= 3'h0;
            end else if (state_change && next_state == ESS_ST_CRANK) begin
                attempts <= attempts + 3'h1; // RQ14
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // registered outputs from next state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fuel_out <= 1'b0;
            glow_out <= 1'b0;
            crank_out <= 1'b0;
            choke_out <= 1'b0;
            stop_out <= 1'b0;
            load_enable <= 1'b0;
            state_code <= 4'h0;
        end else if (ce) begin
            fuel_out <= !sync_rst && next_state inside {ESS_ST_PREHEAT, ESS_ST_CRANK,
                ESS_ST_WAIT, ESS_ST_HEATING, ESS_ST_LOADED, ESS_ST_COOLDOWN};
            glow_out <= !sync_rst && next_state == ESS_ST_PREHEAT; // RQ12
            crank_out <= !sync_rst && next_state == ESS_ST_CRANK; // RQ13 RQ19
            if (sync_rst || next_state != ESS_ST_CRANK || fired) begin
                choke_out <= 1'b0; // RQ18
            end else if (state != ESS_ST_CRANK) begin
                choke_out <= 1'b1; // RQ18
            end else if (seq_cnt >= 16'(choke_s)) begin
                choke_out <= 1'b0; // RQ18
            end
            stop_out <= !sync_rst && next_state == ESS_ST_STOPPING
                        && !(state == ESS_ST_STOPPING && seq_cnt >= 16'(stop_s)); // RQ17
            load_enable <= !sync_rst && next_state == ESS_ST_LOADED; // RQ15
            state_code <= sync_rst ? 4'h0 : 4'(next_state);
        end
    end

    // stop failure and start failure
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stop_failure_warning <= 1'b0;
            start_failure <= 1'b0;
        end else if (ce) begin
            if (sync_rst) begin
                stop_failure_warning <= 1'b0;
                start_failure <= 1'b0;
            end else begin
                if (state == ESS_ST_STOPPING && stp_cnt >= 16'(stop_s)
                    && engine_rpm != 16'h0000) begin
                    stop_failure_warning <= 1'b1; // RQ17
                end
                if (next_state == ESS_ST_FAILED) begin
                    start_failure <= 1'b1; // RQ14
                end
            end
        end
    end
endmodule
`default_nettype wire

/* File: tb/ess_supervisor_assertions.sv */
// concurrent checks on the supervisor ports
`timescale 1ns/100ps
`default_nettype none
module ess_supervisor_assertions (
    input wire logic clk, rst_n, ce, sync_rst, loss_check_en, crank_out, choke_out,
    input wire logic glow_out, fuel_out, load_enable, speed_shutdown, stop_failure_warning,
    input wire logic signal_lost_shutdown, signal_lost_dump, signal_lost_warning,
    input wire logic [15:0] engine_rpm, crank_cut_rpm,
    input wire logic [2:0] num_starts,
    input wire logic [1:0] loss_action,
    input wire logic [3:0] state_code
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n || sync_rst);
    logic [3:0] cranks;
    // crank attempts since the supervisor last reported the stopped state
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cranks <= 4'h0;
        end else if (sync_rst || state_code == 4'h0) begin
            cranks <= 4'h0;
        end else if ($rose(crank_out)) begin
            cranks <= cranks + 4'h1;
        end
    end
    //////////////////////////////////////////////////////////////////////////
    AST_CHOKE_WITH_CRANK: assert property ($rose(choke_out) |-> $rose(crank_out))
        else $error("choke raised without crank");
    AST_GLOW_NEEDS_FUEL: assert property (glow_out |-> fuel_out)
        else $error("glow without fuel");
    AST_CRANK_CUT: assert property (
        crank_out && ce && engine_rpm >= crank_cut_rpm |-> ##[1:3] !crank_out)
        else $error("crank held after engine fired");
    AST_LOAD_AFTER_HEAT: assert property (
        $rose(load_enable) |-> $past(state_code) inside {4'h5, 4'h7})
        else $error("load taken before heating");
    AST_LOSS_ENABLE: assert property (
        $rose(signal_lost_shutdown || signal_lost_dump || signal_lost_warning)
        |-> loss_check_en)
        else $error("loss flagged while check off");
    AST_LOSS_SHUTDOWN: assert property ($rose(signal_lost_shutdown) |-> loss_action == 2'h0)
        else $error("loss shutdown with wrong action");
    AST_LOSS_DUMP: assert property ($rose(signal_lost_dump) |-> loss_action == 2'h1)
        else $error("loss dump with wrong action");
    AST_SHUTDOWN_STOPS: assert property ($rose(speed_shutdown) |-> ##[0:3] !load_enable)
        else $error("load kept after speed shutdown");
    AST_START_COUNT: assert property (cranks <= {1'b0, num_starts})
        else $error("too many crank attempts");
    AST_SYNC_RESET: assert property (disable iff (!rst_n)
        sync_rst && ce |=> state_code == 4'h0 && !fuel_out && !stop_failure_warning)
        else $error("sync reset did not stop");
    cover property ($rose(load_enable));
    cover property ($rose(speed_shutdown));
    cover property ($rose(signal_lost_dump));
endmodule
`default_nettype wire

/* File: tb/ess_engine_model.sv */
// behavioural engine with speed pickup and charge alternator
`timescale 1ns/100ps
`default_nettype none
module ess_engine_model (
    input wire logic clk,
    input wire logic fuel_out, crank_out, stop_out, stall, lose_signal,
    input wire logic [15:0] run_rpm,
    input wire logic [9:0] run_dv,
    output logic [15:0] engine_rpm,
    output logic speed_signal_present,
    output logic [9:0] charge_dv
);
    logic [15:0] rpm = 16'h0000;
    // fires on cranking, stops when fuel is cut unless seized
    always_ff @(negedge clk) begin
        if (!stall && (stop_out || !fuel_out)) rpm <= 16'h0000;
        else if (crank_out || rpm != 16'h0000) rpm <= run_rpm;
    end
    // pickup and alternator only give output while turning
    assign engine_rpm = rpm;
    assign speed_signal_present = (rpm != 16'h0000) && !lose_signal;
    assign charge_dv = (rpm != 16'h0000) ? run_dv : 10'h000;
endmodule
`default_nettype wire

/* File: tb/test_engine_start_stop_supervisor.sv */
// self-checking bench for the supervisor
`timescale 1ns/100ps
`default_nettype none
module test_engine_start_stop_supervisor;
    import ess_pkg::*;
    logic clk = 0, rst_n = 0, ce = 1, sync_rst = 0, mains_fail = 0, speed_signal_present;
    logic loss_check_en = 0, heat_method = 0, stall = 0, lose = 0;
    logic [15:0] engine_rpm, run_rpm = 16'h05DC, crank_cut_rpm = ESS_CRANK_CUT_RPM_RST;
    logic [15:0] nominal_rpm1 = ESS_NOM_RPM1_RST, nominal_rpm2 = ESS_NOM_RPM2_RST;
    logic [15:0] nominal_rpm3 = 16'h03E8;
    logic [9:0] charge_dv, run_dv = 10'h064, chg_warn_dv = ESS_CHG_WARN_DV_RST;
    logic [9:0] chg_sd_dv = ESS_CHG_SD_DV_RST, start_delay_min = 10'h000, cool_s = 10'h000;
    logic [7:0] coolant_temp = 8'h5A, loss_s = 8'h00, wait_s = ESS_WAIT_S_RST, heat_s = 8'h00;
    logic [7:0] heat_temp = 8'h46, choke_s = ESS_CHOKE_S_RST;
    logic [6:0] low_warn_pct = 7'h0A, low_sd_pct = 7'h0F, high_warn_pct = 7'h0A;
    logic [6:0] high_sd_pct = 7'h0F, overshoot_pct = 7'h0A, chg_fail_s = 7'h00, stop_s = 7'h00;
    logic [4:0] preheat_s = 5'h00, want, got;
    logic [3:0] speed_fail_s = 4'h0, crank_s = ESS_CRANK_S_RST, state_code;
    logic [2:0] num_starts = ESS_STARTS_RST;
    logic [1:0] freq_select = 2'h0, loss_action = 2'h0;
    logic fuel_out, glow_out, crank_out, choke_out, stop_out, load_enable, low_speed_warning;
    logic high_speed_warning, speed_shutdown, signal_lost_shutdown, signal_lost_dump;
    logic signal_lost_warning, charge_warning, charge_shutdown, stop_failure_warning;
    logic start_failure;
    int errors = 0, cmp_count = 0;
    // rows: selection, engine speed, charge voltage, {low, high, speed sd, chg warn, chg sd}
    logic [32:0] rows [8] = '{{2'h0, 16'h05DC, 10'h064, 5'h00}, {2'h0, 16'h0514, 10'h064, 5'h10},
        {2'h1, 16'h060E, 10'h064, 5'h10}, {2'h2, 16'h0460, 10'h064, 5'h08},
        {2'h3, 16'h06A4, 10'h064, 5'h08}, {2'h1, 16'h05DC, 10'h064, 5'h04},
        {2'h0, 16'h05DC, 10'h032, 5'h02}, {2'h0, 16'h05DC, 10'h01E, 5'h01}};
    ess_supervisor DUT (.*);
    ess_engine_model u_eng (.clk(clk), .fuel_out(fuel_out), .crank_out(crank_out),
        .stop_out(stop_out), .stall(stall), .lose_signal(lose), .run_rpm(run_rpm),
        .run_dv(run_dv), .engine_rpm(engine_rpm), .speed_signal_present(speed_signal_present),
        .charge_dv(charge_dv));
    // clock
    always #4 clk = ~clk;
    //////////////////////////////////////////////////////////////////////////
    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        cmp_count++;
        if (g !== e) begin
            errors++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // fresh start after a mains failure, at most n cycles to load
    task automatic run_up(input int n);
        sync_rst = 1;
        mains_fail = 0;
        step(1);
        sync_rst = 0;
        mains_fail = 1;
        for (int i = 0; i < n && load_enable !== 1'b1; i++) step(1);
    endtask
    task summarize;
        if (errors == 0 && cmp_count > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    // watchdog
    initial begin
        #500000;
        errors++;
        summarize;
    end
    // main sequence
    initial begin
        step(12);
        rst_n = 1;
        step(1);
        chk({fuel_out, crank_out, stop_out, load_enable, state_code}, 16'h0000);
        for (int r = 0; r < 8; r++) begin
            {freq_select, run_rpm, run_dv, want} = rows[r];
            run_up(400);
            step(20);
            got = {low_speed_warning, high_speed_warning, speed_shutdown, charge_warning,
                charge_shutdown};
            chk(got & ((want & 5'h05) != 5'h00 ? 5'h05 : 5'h1F), want);
        end
        {freq_select, run_rpm, run_dv, speed_fail_s} = {2'h0, 16'h0514, 10'h064, 4'hA};
        run_up(400);
        step(2000);
        chk(low_speed_warning, 1'b0);
        run_rpm = 16'h07D0;
        step(10);
        chk(speed_shutdown, 1'b1);
        {run_rpm, speed_fail_s} = {16'h05DC, 4'h0};
        for (int a = 0; a < 4; a++) begin
            loss_action = 2'(a % 3);
            run_up(400);
            loss_check_en = (a < 3);
            lose = 1;
            step(20);
            chk({signal_lost_shutdown, signal_lost_dump, signal_lost_warning},
                a == 3 ? 3'b000 : 3'b100 >> a);
            {lose, loss_check_en} = 2'h0;
        end
        start_delay_min = 10'h001;
        run_up(1000);
        chk({fuel_out, state_code}, 5'h01);
        {start_delay_min, heat_method, coolant_temp} = {10'h000, 1'b1, 8'h14};
        run_up(1000);
        chk({load_enable, state_code}, 5'h05);
        coolant_temp = 8'h4B;
        step(20);
        chk(load_enable, 1'b1);
        heat_method = 0;
        run_up(400);
        mains_fail = 0;
        step(20);
        chk(load_enable, 1'b0);
        step(30);
        chk({stop_failure_warning, state_code}, 5'h00);
        run_up(400);
        stall = 1;
        mains_fail = 0;
        step(40);
        chk(stop_failure_warning, 1'b1);
        {stall, crank_s, wait_s, run_rpm} = {1'b0, 4'h0, 8'h00, 16'h0064};
        run_up(60);
        chk(start_failure, 1'b1);
        summarize;
    end
endmodule
bind ess_supervisor ess_supervisor_assertions u_chk (.*);
`default_nettype wire
